/* File: sbsi_core.sv */
// command decode, burst control, bus drive and storage of the burst sram
`timescale 1ns/10ps

module sbsi_core #(
  parameter int ADDR_W = sbsi_pkg::DEF_ADDR_W,
  parameter int LANES = sbsi_pkg::DEF_LANES
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [ADDR_W-1:0] address_i,
  input wire logic chip_select_one_n_i,
  input wire logic chip_select_two_i,
  input wire logic chip_select_three_n_i,
  input wire logic sleep_request_i,
  input wire logic burst_advance_load_i,
  input wire logic write_enable_n_i,
  input wire logic [LANES-1:0] byte_write_select_n_i,
  input wire logic clock_qualifier_n_i,
  input wire logic output_enable_n_i,
  input wire logic burst_order_i,
  input wire logic [LANES*sbsi_pkg::LANE_DATA_BITS-1:0] data_i,
  output logic [LANES*sbsi_pkg::LANE_DATA_BITS-1:0] data_o,
  output logic data_oe_n_o,
  input wire logic [LANES-1:0] byte_parity_lines_i,
  output logic [LANES-1:0] byte_parity_lines_o,
  output logic byte_parity_lines_oe_n_o,
  output logic sleep_active_o,
  output logic write_accept_o
);

  localparam int LW = sbsi_pkg::LANE_BITS;
  localparam int LD = sbsi_pkg::LANE_DATA_BITS;
  localparam int WW = LANES * LW;
  localparam int AW = sbsi_pkg::MAX_ADDR_W;
  localparam int EW = sbsi_pkg::MAX_LANES * LW;
  localparam int ML = sbsi_pkg::MAX_LANES;
  localparam int DEPTH = 1 << ADDR_W;
  localparam int BB = sbsi_pkg::BURST_BITS;

  initial begin
    if (LANES != 2 && LANES != 4) begin
      $error("sbsi_core: LANES must be 2 or 4");
    end
    if (ADDR_W < BB + 1 || ADDR_W > AW) begin
      $error("sbsi_core: ADDR_W out of range");
    end
    if (sbsi_pkg::WRITE_FIFO_DEPTH < 2) begin
      $error("sbsi_core: write fifo needs room for push and drain");
    end
  end

  // ==========================================================================
  // functions
  function automatic logic [BB-1:0] burst_offset(input logic [BB-1:0] start, input logic [BB-1:0] step,
                                                 input logic order);
    if (order == sbsi_pkg::BURST_ORDER_INTERLEAVED) begin
      burst_offset = start ^ step;
    end else begin
      burst_offset = start + step;
    end
  endfunction : burst_offset

  function automatic logic [WW-1:0] merge_lanes(input logic [WW-1:0] old_w, input logic [WW-1:0] new_w,
                                                input logic [LANES-1:0] mask);
    logic [WW-1:0] res;
    res = old_w;
    for (int i = 0; i < LANES; i++) begin
      if (mask[i]) res[i*LW +: LW] = new_w[i*LW +: LW];
    end
    merge_lanes = res;
  endfunction : merge_lanes

  // ==========================================================================
  // pin synchronisers
  logic sleep_meta;
  logic sleep_sync;
  logic order_meta;
  logic order_sync;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sleep_meta <= 1'b0;
      sleep_sync <= 1'b0;
      order_meta <= 1'b0;
      order_sync <= 1'b0;
    end else begin
      sleep_meta <= sleep_request_i;
      sleep_sync <= sleep_meta;
      order_meta <= burst_order_i;
      order_sync <= order_meta;
    end
  end

  // ==========================================================================
  // sleep sequencer
  sbsi_pkg::sbsi_sleep_t sleep_state;
  sbsi_pkg::sbsi_sleep_t next_sleep_state;
  logic [sbsi_pkg::SLEEP_CNT_W-1:0] sleep_cnt;
  logic [sbsi_pkg::SLEEP_CNT_W-1:0] next_sleep_cnt;

  localparam logic [sbsi_pkg::SLEEP_CNT_W-1:0] SLEEP_LAST =
    sbsi_pkg::SLEEP_CNT_W'(sbsi_pkg::SLEEP_TRANSITION_CYCLES - 1);

  always_comb begin
    next_sleep_state = sleep_state;
    next_sleep_cnt = sleep_cnt;
    case (sleep_state)
      sbsi_pkg::SBSI_SLEEP_AWAKE: begin
        next_sleep_cnt = '0;
        if (sleep_sync) next_sleep_state = sbsi_pkg::SBSI_SLEEP_ENTER;
      end
      sbsi_pkg::SBSI_SLEEP_ENTER: begin
        next_sleep_cnt = sleep_cnt + 1'b1;
        if (sleep_cnt == SLEEP_LAST) begin
          next_sleep_state = sbsi_pkg::SBSI_SLEEP_ASLEEP;
          next_sleep_cnt = '0;
        end
      end
      sbsi_pkg::SBSI_SLEEP_ASLEEP: begin
        next_sleep_cnt = '0;
        if (!sleep_sync) next_sleep_state = sbsi_pkg::SBSI_SLEEP_EXIT;
      end
      sbsi_pkg::SBSI_SLEEP_EXIT: begin
        next_sleep_cnt = sleep_cnt + 1'b1;
        if (sleep_cnt == SLEEP_LAST) begin
          next_sleep_state = sbsi_pkg::SBSI_SLEEP_AWAKE;
          next_sleep_cnt = '0;
        end
      end
      default: begin
        next_sleep_state = sbsi_pkg::SBSI_SLEEP_AWAKE;
        next_sleep_cnt = '0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sleep_state <= sbsi_pkg::SBSI_SLEEP_AWAKE;
      sleep_cnt <= '0;
    end else begin
      sleep_state <= next_sleep_state;
      sleep_cnt <= next_sleep_cnt;
    end
  end

  wire awake = (sleep_state == sbsi_pkg::SBSI_SLEEP_AWAKE);
  wire sleep_begin = awake && sleep_sync;

  // ==========================================================================
  // sleep status flag
  logic sleep_flag;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sleep_flag <= 1'b0;
    end else begin
      sleep_flag <= (next_sleep_state != sbsi_pkg::SBSI_SLEEP_AWAKE);
    end
  end

  // ==========================================================================
  // command decode
  sbsi_pkg::sbsi_op_t op;
  sbsi_pkg::sbsi_op_t next_op;
  logic [ADDR_W-1:0] base;
  logic [ADDR_W-1:0] next_base;
  logic [BB-1:0] step;
  logic [BB-1:0] next_step;
  logic wr_pend;
  logic [ADDR_W-1:0] wr_addr;
  logic [LANES-1:0] wr_mask;
  logic [WW-1:0] rd_word;

  wire edge_ok = awake && !sleep_sync && !clock_qualifier_n_i;
  wire selected = !chip_select_one_n_i && chip_select_two_i && !chip_select_three_n_i;
  wire [LANES-1:0] lane_sel = ~byte_write_select_n_i;
  wire any_lane = |lane_sel;
  wire load_cmd = edge_ok && !burst_advance_load_i;
  wire start_read = load_cmd && selected && write_enable_n_i;
  wire start_write = load_cmd && selected && !write_enable_n_i && any_lane;
  wire start_abort = load_cmd && selected && !write_enable_n_i && !any_lane;
  wire start_desel = load_cmd && !selected;
  wire cont = edge_ok && burst_advance_load_i && (op != sbsi_pkg::SBSI_OP_DESELECT);
  wire cont_read = cont && (op == sbsi_pkg::SBSI_OP_READ);
  wire cont_write = cont && (op == sbsi_pkg::SBSI_OP_WRITE) && any_lane;
  wire [BB-1:0] step_inc = step + 1'b1;
  wire [ADDR_W-1:0] cont_addr = {base[ADDR_W-1:BB], burst_offset(base[BB-1:0], step_inc, order_sync)};
  wire [ADDR_W-1:0] access_addr = (start_read || start_write) ? address_i : cont_addr;
  wire capture = edge_ok && wr_pend;

  always_comb begin
    next_op = op;
    next_base = base;
    next_step = step;
    if (start_read) begin
      next_op = sbsi_pkg::SBSI_OP_READ;
      next_base = address_i;
      next_step = '0;
    end else if (start_write) begin
      next_op = sbsi_pkg::SBSI_OP_WRITE;
      next_base = address_i;
      next_step = '0;
    end else if (start_abort) begin
      next_op = sbsi_pkg::SBSI_OP_WRITE;
      next_step = '0;
    end else if (start_desel) begin
      next_op = sbsi_pkg::SBSI_OP_DESELECT;
    end else if (cont) begin
      next_step = step_inc;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      op <= sbsi_pkg::SBSI_OP_DESELECT;
      base <= '0;
      step <= '0;
    end else if (sleep_begin) begin
      op <= sbsi_pkg::SBSI_OP_DESELECT;
    end else begin
      op <= next_op;
      base <= next_base;
      step <= next_step;
    end
  end

  // ==========================================================================
  // pending write: address and lanes wait one edge for their data
  always_ff @(posedge clk_i) begin
    if (reset_i || sleep_begin) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
      wr_mask <= '0;
    end else if (edge_ok) begin
      wr_pend <= start_write || cont_write;
      wr_addr <= access_addr;
      wr_mask <= lane_sel;
    end
  end

  // ==========================================================================
  // bus lane packing
  logic [WW-1:0] bus_word;

  for (genvar g = 0; g < LANES; g++) begin : g_lane
    assign bus_word[g*LW +: LW] = {byte_parity_lines_i[g], data_i[g*LD +: LD]};
    assign data_o[g*LD +: LD] = rd_word[g*LW +: LD];
    assign byte_parity_lines_o[g] = rd_word[g*LW + LD];
  end

  // ==========================================================================
  // write fifo between capture and array
  sbsi_pkg::sbsi_wr_entry_t in_entry;
  sbsi_pkg::sbsi_wr_entry_t head;
  logic fifo_in_ready;
  logic head_valid;

  assign in_entry.addr = AW'(wr_addr);
  assign in_entry.word = EW'(bus_word);
  assign in_entry.mask = ML'(wr_mask);
  assign write_accept_o = fifo_in_ready;

  sbsi_fifo #(
    .WIDTH($bits(sbsi_pkg::sbsi_wr_entry_t)),
    .DEPTH(sbsi_pkg::WRITE_FIFO_DEPTH)
  ) u_wr_fifo (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .in_valid_i(capture),
    .in_ready_o(fifo_in_ready),
    .in_data_i(in_entry),
    .out_valid_o(head_valid),
    .out_ready_i(awake),
    .out_data_o(head)
  );

  // ==========================================================================
  // storage array
  logic [WW-1:0] mem [DEPTH];

  wire [ADDR_W-1:0] head_addr = head.addr[ADDR_W-1:0];
  wire [WW-1:0] head_word = head.word[WW-1:0];
  wire [LANES-1:0] head_mask = head.mask[LANES-1:0];
  wire drain = head_valid && awake;

  always_ff @(posedge clk_i) begin
    if (drain) begin
      mem[head_addr] <= merge_lanes(mem[head_addr], head_word, head_mask);
    end
  end

  // ==========================================================================
  // read path with forwarding of writes not yet in the array
  wire [WW-1:0] arr_word = mem[access_addr];
  wire fwd_head = head_valid && (head_addr == access_addr);
  wire [WW-1:0] word_a = fwd_head ? merge_lanes(arr_word, head_word, head_mask) : arr_word;
  wire fwd_bus = capture && (wr_addr == access_addr);
  wire [WW-1:0] word_b = fwd_bus ? merge_lanes(word_a, bus_word, wr_mask) : word_a;
  wire rd_load = start_read || cont_read;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rd_word <= '0;
    end else if (rd_load) begin
      rd_word <= word_b;
    end
  end

  // ==========================================================================
  // data bus drive
  wire read_cycle = awake && (op == sbsi_pkg::SBSI_OP_READ);
  wire write_cycle = (op == sbsi_pkg::SBSI_OP_WRITE);
  wire oe_unmasked = !output_enable_n_i && !write_cycle;
  wire drive_en = read_cycle && oe_unmasked;

  assign data_oe_n_o = !drive_en;
  assign byte_parity_lines_oe_n_o = !drive_en;
  assign sleep_active_o = sleep_flag;

endmodule : sbsi_core

/* File: sbsi_pkg.sv */
// shared constants and types of the synchronous burst sram interface
package sbsi_pkg;

  // ==========================================================================
  // organisation
  localparam int MAX_ADDR_W = 20;
  localparam int MAX_LANES = 4;
  localparam int LANE_DATA_BITS = 8;
  localparam int LANE_BITS = 9;
  localparam int DEF_ADDR_W = 19;
  localparam int DEF_LANES = 4;
  localparam int BURST_BITS = 2;

  // ==========================================================================
  // burst order strap levels
  localparam logic BURST_ORDER_LINEAR = 1'b0;
  localparam logic BURST_ORDER_INTERLEAVED = 1'b1;

  // ==========================================================================
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int SLEEP_TRANSITION_CYCLES = 2;
  localparam int SLEEP_CNT_W = 2;
  localparam int WRITE_FIFO_DEPTH = 4;

  // ==========================================================================
  // types
  typedef enum logic [1:0] {
    SBSI_OP_DESELECT,
    SBSI_OP_READ,
    SBSI_OP_WRITE
  } sbsi_op_t;

  typedef enum logic [1:0] {
    SBSI_SLEEP_AWAKE,
    SBSI_SLEEP_ENTER,
    SBSI_SLEEP_ASLEEP,
    SBSI_SLEEP_EXIT
  } sbsi_sleep_t;

  typedef struct packed {
    logic [MAX_ADDR_W-1:0] addr;
    logic [MAX_LANES*LANE_BITS-1:0] word;
    logic [MAX_LANES-1:0] mask;
  } sbsi_wr_entry_t;

endpackage : sbsi_pkg

/* File: sbsi_fifo.sv */
// small synchronous fifo holding captured write data
`timescale 1ns/10ps
module sbsi_fifo #(
  parameter int WIDTH = 60,
  parameter int DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int PTR_W = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
      $error("sbsi_fifo: DEPTH must be a power of two of at least 2");
    end
  end

  // ==========================================================================
  // storage and pointers
  logic [WIDTH-1:0] slots [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W:0] count;

  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;

  assign in_ready_o = (count != (PTR_W+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o = slots[rd_ptr];

  always_ff @(posedge clk_i) begin
    if (push) begin
      slots[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
      if (push && !pop) count <= count + 1'b1;
      else if (pop && !push) count <= count - 1'b1;
    end
  end

endmodule : sbsi_fifo

/* File: sbsi_core_props.sv */
// concurrent checks on the ports of the burst sram core
`timescale 1ns/10ps
module sbsi_core_chk #(
  parameter int LANES = 4
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic chip_select_one_n_i,
  input wire logic chip_select_two_i,
  input wire logic chip_select_three_n_i,
  input wire logic sleep_request_i,
  input wire logic burst_advance_load_i,
  input wire logic write_enable_n_i,
  input wire logic clock_qualifier_n_i,
  input wire logic output_enable_n_i,
  input wire logic [LANES*sbsi_pkg::LANE_DATA_BITS-1:0] data_o,
  input wire logic data_oe_n_o,
  input wire logic [LANES-1:0] byte_parity_lines_o,
  input wire logic byte_parity_lines_oe_n_o,
  input wire logic sleep_active_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  // ==========================================================================
  // decode helpers
  wire sel = !chip_select_one_n_i && chip_select_two_i && !chip_select_three_n_i;
  wire load_ok = !clock_qualifier_n_i && !burst_advance_load_i && !sleep_active_o;
  wire float = data_oe_n_o && byte_parity_lines_oe_n_o;
  // ==========================================================================
  // properties
  property p_write_float;
    (!sleep_request_i)[*3] ##0 (load_ok && sel && !write_enable_n_i) |=> float;
  endproperty
  a_write_float: assert property (p_write_float) else $error("bus driven in write");
  property p_read_drive;
    (!sleep_request_i)[*3] ##0 (load_ok && sel && write_enable_n_i) ##1 !output_enable_n_i |-> !data_oe_n_o;
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("read not driven");
  property p_oe_gate;
    output_enable_n_i |-> float;
  endproperty
  a_oe_gate: assert property (p_oe_gate) else $error("driven with oe high");
  property p_deselect;
    (load_ok && !sel) |=> float;
  endproperty
  a_deselect: assert property (p_deselect) else $error("driven after deselect");
  property p_deselect_hold;
    (load_ok && !sel) ##1 (!clock_qualifier_n_i && burst_advance_load_i) |=> float;
  endproperty
  a_deselect_hold: assert property (p_deselect_hold) else $error("driven in held deselect");
  property p_stall;
    (!sleep_request_i)[*3] ##0 clock_qualifier_n_i |=> $stable(data_o) && $stable(byte_parity_lines_o);
  endproperty
  a_stall: assert property (p_stall) else $error("stalled edge changed data");
  property p_sleep_float;
    sleep_active_o |-> float;
  endproperty
  a_sleep_float: assert property (p_sleep_float) else $error("driven in sleep");
  property p_sleep_enter;
    sleep_request_i[*4] |-> ##[0:2] sleep_active_o;
  endproperty
  a_sleep_enter: assert property (p_sleep_enter) else $error("sleep not entered");
  property p_sleep_exit;
    (!sleep_request_i)[*8] |-> ##[0:2] !sleep_active_o;
  endproperty
  a_sleep_exit: assert property (p_sleep_exit) else $error("sleep not left");
endmodule : sbsi_core_chk

bind sbsi_core sbsi_core_chk #(.LANES(LANES)) chk (
  .clk_i(clk_i),
  .reset_i(reset_i),
  .chip_select_one_n_i(chip_select_one_n_i),
  .chip_select_two_i(chip_select_two_i),
  .chip_select_three_n_i(chip_select_three_n_i),
  .sleep_request_i(sleep_request_i),
  .burst_advance_load_i(burst_advance_load_i),
  .write_enable_n_i(write_enable_n_i),
  .clock_qualifier_n_i(clock_qualifier_n_i),
  .output_enable_n_i(output_enable_n_i),
  .data_o(data_o),
  .data_oe_n_o(data_oe_n_o),
  .byte_parity_lines_o(byte_parity_lines_o),
  .byte_parity_lines_oe_n_o(byte_parity_lines_oe_n_o),
  .sleep_active_o(sleep_active_o)
);

/* File: sbsi_ctrl_model.sv */
// memory controller model driving command and write data pins
`timescale 1ns/10ps
module sbsi_ctrl_model (
  input wire logic clk_i,
  output logic [18:0] address_o,
  output logic chip_select_one_n_o,
  output logic chip_select_two_o,
  output logic chip_select_three_n_o,
  output logic burst_advance_load_o,
  output logic write_enable_n_o,
  output logic [3:0] byte_write_select_n_o,
  output logic clock_qualifier_n_o,
  output logic [31:0] data_o,
  output logic [3:0] byte_parity_lines_o
);
  initial begin
    address_o = 19'h0;
    chip_select_one_n_o = 1'b1;
    chip_select_two_o = 1'b0;
    chip_select_three_n_o = 1'b1;
    burst_advance_load_o = 1'b0;
    write_enable_n_o = 1'b1;
    byte_write_select_n_o = 4'hF;
    clock_qualifier_n_o = 1'b0;
    data_o = 32'h0;
    byte_parity_lines_o = 4'h0;
  end
  // ==========================================================================
  // one taken edge; sel 0 selects, 1..3 each drop one chip select
  task automatic cyc(input logic adv, input logic we_n, input logic [1:0] sel, input logic [3:0] bw,
                     input logic [18:0] a, input logic dv, input logic [35:0] d);
    burst_advance_load_o = adv;
    write_enable_n_o = we_n;
    chip_select_one_n_o = (sel == 2'h1);
    chip_select_two_o = (sel != 2'h2);
    chip_select_three_n_o = (sel == 2'h3);
    byte_write_select_n_o = bw;
    address_o = a;
    clock_qualifier_n_o = 1'b0;
    // released lines show the inverse of their last value
    {byte_parity_lines_o, data_o} = dv ? d : ~{byte_parity_lines_o, data_o};
    @(posedge clk_i);
    @(negedge clk_i);
  endtask : cyc
  // ==========================================================================
  // ignored edge with advance, write enable, address, data and parity pins scrambled
  task automatic stall();
    clock_qualifier_n_o = 1'b1;
    burst_advance_load_o = ~burst_advance_load_o;
    write_enable_n_o = ~write_enable_n_o;
    address_o = ~address_o;
    {byte_parity_lines_o, data_o} = ~{byte_parity_lines_o, data_o};
    @(posedge clk_i);
    @(negedge clk_i);
  endtask : stall
endmodule : sbsi_ctrl_model

/* File: sbsi_core_bench.sv */
// self-checking bench of the burst sram core
`timescale 1ns/10ps
module sbsi_core_bench;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic sleep_request_i = 1'b0;
  logic output_enable_n_i = 1'b0;
  logic burst_order_i = 1'b0;
  logic [18:0] c_addr;
  logic c_cs1_n, c_cs2, c_cs3_n, c_adv, c_we_n, c_cqn;
  logic [3:0] c_bw, c_wp, rp;
  logic [31:0] c_wd, rd;
  logic doe_n, poe_n, slp, acc;
  sbsi_pkg::sbsi_op_t op;
  logic [18:0] base, pa;
  logic [1:0] stp;
  logic pv;
  logic [3:0] pbw;
  logic [35:0] pd;
  logic [35:0] mem [logic [18:0]];
  logic [3:0] bwp [6] = '{4'hE, 4'hD, 4'hB, 4'h7, 4'hA, 4'h5};
  int fail_count = 0;
  int tests_run = 0;
  int i;
  always #25 clk_i = ~clk_i;
  sbsi_ctrl_model ctl (.clk_i(clk_i), .address_o(c_addr), .chip_select_one_n_o(c_cs1_n),
    .chip_select_two_o(c_cs2), .chip_select_three_n_o(c_cs3_n), .burst_advance_load_o(c_adv),
    .write_enable_n_o(c_we_n), .byte_write_select_n_o(c_bw), .clock_qualifier_n_o(c_cqn),
    .data_o(c_wd), .byte_parity_lines_o(c_wp));
  sbsi_core #(.ADDR_W(19), .LANES(4)) dut (.clk_i(clk_i), .reset_i(reset_i), .address_i(c_addr),
    .chip_select_one_n_i(c_cs1_n), .chip_select_two_i(c_cs2), .chip_select_three_n_i(c_cs3_n),
    .sleep_request_i(sleep_request_i), .burst_advance_load_i(c_adv), .write_enable_n_i(c_we_n),
    .byte_write_select_n_i(c_bw), .clock_qualifier_n_i(c_cqn), .output_enable_n_i(output_enable_n_i),
    .burst_order_i(burst_order_i), .data_i(c_wd), .data_o(rd), .data_oe_n_o(doe_n),
    .byte_parity_lines_i(c_wp), .byte_parity_lines_o(rp), .byte_parity_lines_oe_n_o(poe_n),
    .sleep_active_o(slp), .write_accept_o(acc));
  // ==========================================================================
  // checking
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out
  task automatic check(input string what, input logic [35:0] exp, input logic [35:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  function automatic logic [18:0] cur_addr();
    return {base[18:2], burst_order_i ? base[1:0] ^ stp : base[1:0] + stp};
  endfunction : cur_addr
  task automatic chk_out();
    logic [35:0] e;
    e = {35'h0, !(op == sbsi_pkg::SBSI_OP_READ && !output_enable_n_i)};
    check("data drive", e, {35'h0, doe_n});
    check("parity drive", e, {35'h0, poe_n});
    if (op == sbsi_pkg::SBSI_OP_READ && mem.exists(cur_addr())) check("read", mem[cur_addr()], {rp, rd});
  endtask : chk_out
  // ==========================================================================
  // one command; d is the data this command writes at the following edge
  task automatic step(input logic adv, input logic we_n, input logic [1:0] sel, input logic [3:0] bw,
                      input logic [18:0] a, input logic [35:0] d);
    int k;
    ctl.cyc(adv, we_n, sel, bw, a, pv, pd);
    for (k = 0; k < 4; k++) begin
      if (pv && !pbw[k]) begin
        mem[pa][k*8 +: 8] = pd[k*8 +: 8];
        mem[pa][32+k] = pd[32+k];
      end
    end
    if (!adv) begin
      stp = 2'h0;
      if (sel != 2'h0) op = sbsi_pkg::SBSI_OP_DESELECT;
      else if (we_n) op = sbsi_pkg::SBSI_OP_READ;
      else op = sbsi_pkg::SBSI_OP_WRITE;
      if (sel == 2'h0 && (we_n || bw != 4'hF)) base = a;
    end else if (op != sbsi_pkg::SBSI_OP_DESELECT) stp = stp + 2'h1;
    pa = cur_addr();
    pbw = bw;
    pd = d;
    pv = (op == sbsi_pkg::SBSI_OP_WRITE && bw != 4'hF);
    chk_out();
  endtask : step
  // ==========================================================================
  // sequence
  initial begin
    #(50 * 2000);
    fail_count++;
    close_out();
  end
  initial begin
    op = sbsi_pkg::SBSI_OP_DESELECT;
    base = 19'h0;
    stp = 2'h0;
    pv = 1'b0;
    pa = 19'h0;
    pbw = 4'hF;
    pd = 36'h0;
    repeat (20) @(posedge clk_i);
    @(negedge clk_i);
    check("reset drive", 36'h1, {35'h0, doe_n});
    check("reset sleep", 36'h0, {35'h0, slp});
    reset_i = 1'b0;
    for (i = 0; i < 4; i++) step(i != 0, 1'b0, 2'h0, 4'h0, 19'h1, 36'h912345670 + 36'(i));
    for (i = 0; i < 4; i++) begin
      step(i != 0, 1'b1, 2'h0, 4'h0, 19'h1, 36'h0);
      if (i == 1) ctl.stall();
      if (i == 1) chk_out();
    end
    check("room", 36'h1, {35'h0, acc});
    step(1'b0, 1'b0, 2'h0, 4'h0, 19'h10, 36'hF00FF00FF);
    for (i = 0; i < 6; i++) begin
      step(1'b0, 1'b0, 2'h0, bwp[i], 19'h10, 36'h123456789 * 36'(i + 1));
      step(1'b0, 1'b1, 2'h0, 4'hF, 19'h10, 36'h0);
    end
    step(1'b0, 1'b0, 2'h0, 4'hF, 19'h10, 36'hFFFFFFFFF);
    step(1'b1, 1'b0, 2'h0, 4'hF, 19'h0, 36'hFFFFFFFFF);
    step(1'b0, 1'b1, 2'h0, 4'hF, 19'h10, 36'h0);
    for (i = 1; i < 4; i++) step(1'b0, 1'b0, 2'(i), 4'h0, 19'h1, 36'hFFFFFFFFF);
    step(1'b1, 1'b0, 2'h0, 4'h0, 19'h1, 36'hFFFFFFFFF);
    output_enable_n_i = 1'b1;
    step(1'b0, 1'b1, 2'h0, 4'hF, 19'h3, 36'h0);
    step(1'b1, 1'b1, 2'h0, 4'hF, 19'h3, 36'h0);
    output_enable_n_i = 1'b0;
    #1;
    check("async drive", 36'h0, {35'h0, doe_n});
    burst_order_i = 1'b1;
    for (i = 0; i < 3; i++) step(1'b0, 1'b1, 2'h1, 4'hF, 19'h0, 36'h0);
    for (i = 0; i < 4; i++) step(i != 0, 1'b1, 2'h0, 4'hF, 19'h1, 36'h0);
    step(1'b0, 1'b1, 2'h1, 4'hF, 19'h0, 36'h0);
    sleep_request_i = 1'b1;
    for (i = 0; i < 8; i++) step(1'b1, 1'b1, 2'h0, 4'hF, 19'h0, 36'h0);
    check("asleep", 36'h1, {35'h0, slp});
    sleep_request_i = 1'b0;
    for (i = 0; i < 12 && slp !== 1'b0; i++) step(1'b1, 1'b1, 2'h0, 4'hF, 19'h0, 36'h0);
    check("awake", 36'h0, {35'h0, slp});
    check("wake cycles", 36'(3 + sbsi_pkg::SLEEP_TRANSITION_CYCLES), 36'(i));
    step(1'b1, 1'b1, 2'h0, 4'hF, 19'h0, 36'h0);
    step(1'b0, 1'b1, 2'h0, 4'hF, 19'h10, 36'h0);
    close_out();
  end
endmodule : sbsi_core_bench
